//--- logic/rfb_bank.sv
// Receive FIFO, its status flags and the isochronous control registers
// How it works
// - Flags read-only without diagnostic enable, control bits read/write except clear bit 19
// - Status register resets to zero except size bits 26-31
// - Bit 0 set when FIFO full
// - Bit 1 set when one slot left
// - Bit 4 set when four slots free
// - Bit 12 set when four words held
// - Bit 14 set when one word held
// - Bit 15 empty; reads then ignored
// - Flag writes only with diagnostic enable
// - Bit 16 marks packet's first quadlet
// - Bit 19 clears the whole FIFO
// - Bits 26-31 size, resets to 0x32
// - Transmit remaining count in bits 18-23
// - Receive remaining count in bits 26-31
// - Block and packet counts software programmed
// - Bit 0 marks isochronous transmit ready
// - Direction 00 transmit, 01 receive
// - Receive accepted by port enables only
// - Header bits 0-15 byte length
// - Tag bits 16-17, channel 18-23
// - Speed bits 26-27, resets to 00
// - Header bits 28-31 set sync bits in transmit direction only
`timescale 1ns/1ps
`include "rfb_regs.svh"

// ----------------------------------------------------------------
// FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module rfb_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [AW:0]      count
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (cnt_reg != (AW + 1)'(DEPTH)) || out_ready && out_valid;
	assign out_valid = cnt_reg != '0;
	assign out_data  = mem_reg[rd_reg];
	assign count     = cnt_reg;

	// Pointers and count; flush drops everything at once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	// Storage is plain flops without reset
	always_ff @(posedge clk) begin
		if (push && !flush)
			mem_reg[wr_reg] <= in_data;
	end
endmodule // rfb_fifo

// ----------------------------------------------------------------
// Register bank top
// ----------------------------------------------------------------
module rfb_bank #(
	parameter int DEPTH = 16
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  host_cs,
	input  wire logic                  host_wr,
	input  wire logic                  host_rd,
	input  wire rfb_pkg::rfb_addr_t    host_addr,
	input  wire rfb_pkg::rfb_word_t    host_wdata,
	output rfb_pkg::rfb_word_t         host_rdata,
	input  wire logic                  diag_register_write,
	input  wire logic [1:0]            iso_receive_port_enable,
	input  wire logic                  rx_valid,
	input  wire logic                  rx_iso,
	input  wire logic                  rx_port,
	input  wire logic                  rx_first,
	input  wire rfb_pkg::rfb_word_t    rx_data,
	output logic                       rx_ready,
	input  wire logic [5:0]            tx_fifo_remaining,
	output logic                       iso_start_enable,
	output logic [1:0]                 iso_direction,
	output logic [21:0]                iso_quads_per_block,
	output logic [9:0]                 iso_quads_per_packet,
	output logic [15:0]                iso_length,
	output logic [1:0]                 iso_tag,
	output logic [5:0]                 iso_channel,
	output logic [1:0]                 iso_speed,
	output logic [3:0]                 iso_sync_bits
);
	localparam int AW = $clog2(DEPTH);

	rfb_pkg::rfb_word_t status_reg;
	rfb_pkg::rfb_word_t sizes_reg;
	rfb_pkg::rfb_word_t dir_reg;
	rfb_pkg::rfb_word_t header_reg;
	rfb_pkg::rfb_word_t rdata_reg;
	logic               ovr_reg;
	logic [AW:0]        count;
	logic               fifo_valid;
	logic [32:0]        fifo_out;
	logic               fifo_ready_in;

	// Host strobes decoded by address
	wire wr_en      = host_cs && host_wr;
	wire rd_en      = host_cs && host_rd;
	wire wr_status  = wr_en && host_addr == `RFB_OFS_RX_STATUS;
	wire wr_sizes   = wr_en && host_addr == `RFB_OFS_ISO_SIZES;
	wire wr_dir     = wr_en && host_addr == `RFB_OFS_ISO_DIR;
	wire wr_header  = wr_en && host_addr == `RFB_OFS_ISO_HEADER;
	wire rd_data    = rd_en && host_addr == `RFB_OFS_RX_DATA && fifo_valid;
	wire clear_fifo = wr_status && host_wdata[`RFB_BIT_CLEAR];

	// Packets blocked only by the port enables, never by direction
	wire rx_accept  = !rx_iso || iso_receive_port_enable[rx_port];
	wire in_valid   = rx_valid && rx_accept;
	assign rx_ready = fifo_ready_in || !rx_accept;

	rfb_fifo #(.WIDTH(33), .DEPTH(DEPTH)) u_fifo (
		.clk      (clk),
		.nrst     (nrst),
		.flush    (clear_fifo),
		.in_valid (in_valid),
		.in_ready (fifo_ready_in),
		.in_data  ({rx_first, rx_data}),
		.out_valid(fifo_valid),
		.out_ready(rd_data),
		.out_data (fifo_out),
		.count    (count)
	);

	// Live occupancy flags
	wire [AW:0] free       = (AW + 1)'(DEPTH) - count;
	wire        f_full     = free == '0;
	wire        f_afull    = free == (AW + 1)'(1);
	wire        f_four_sp  = free >= (AW + 1)'(4);
	wire        f_four_pr  = count >= (AW + 1)'(4);
	wire        f_aempty   = count == (AW + 1)'(1);
	wire        f_empty    = count == '0;
	wire        f_first    = fifo_valid && fifo_out[32];
	wire [31:0] live_flags = 32'(f_full) << `RFB_BIT_FULL
		| 32'(f_afull) << `RFB_BIT_ALMOST_FULL
		| 32'(f_four_sp) << `RFB_BIT_FOUR_SPACE
		| 32'(f_four_pr) << `RFB_BIT_FOUR_PRES
		| 32'(f_aempty) << `RFB_BIT_ALMOST_EMPT
		| 32'(f_empty) << `RFB_BIT_EMPTY;
	// Diagnostic override holds written flag values instead of live ones
	wire [31:0] flags      = ovr_reg ? (status_reg & `RFB_FLAG_MASK) : live_flags;
	wire [31:0] status_rd  = flags
		| 32'(f_first) << `RFB_BIT_FIRST_QUAD
		| (status_reg & ~`RFB_FLAG_MASK);
	wire [31:0] levels_rd  = 32'(tx_fifo_remaining) << `RFB_TX_REMAIN_LSB
		| 32'(count) << `RFB_RX_REMAIN_LSB;

	// Status: clear bit self-clears; flags stored only under diagnostic enable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_reg <= `RFB_STATUS_RESET | (32'(`RFB_SIZE_RESET) << `RFB_SIZE_LSB);
			ovr_reg    <= 1'b0;
		end else if (wr_status) begin
			status_reg <= (32'hFC000000 & host_wdata)
				| (diag_register_write ? (host_wdata & `RFB_FLAG_MASK) : 32'h0);
			ovr_reg    <= diag_register_write;
		end
	end

	// Isochronous registers; reserved bits never stored
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sizes_reg  <= 32'h0;
			dir_reg    <= 32'h0;
			header_reg <= 32'h0;
		end else begin
			if (wr_sizes)
				sizes_reg <= host_wdata;
			if (wr_dir)
				dir_reg <= host_wdata & `RFB_ISO_DIR_MASK;
			if (wr_header)
				header_reg <= host_wdata & `RFB_ISO_HDR_MASK;
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdata_reg <= 32'h0;
		else if (rd_en) begin
			if (host_addr == `RFB_OFS_RX_STATUS)
				rdata_reg <= status_rd;
			else if (host_addr == `RFB_OFS_FILL_LEVELS)
				rdata_reg <= levels_rd;
			else if (host_addr == `RFB_OFS_ISO_SIZES)
				rdata_reg <= sizes_reg;
			else if (host_addr == `RFB_OFS_ISO_DIR)
				rdata_reg <= dir_reg;
			else if (host_addr == `RFB_OFS_ISO_HEADER)
				rdata_reg <= header_reg;
			else if (host_addr == `RFB_OFS_RX_DATA)
				rdata_reg <= fifo_valid ? fifo_out[31:0] : 32'h0;
			else
				rdata_reg <= 32'h0;
		end
	end

	assign host_rdata           = rdata_reg;
	assign iso_start_enable     = dir_reg[0];
	assign iso_direction        = dir_reg[2:1];
	assign iso_quads_per_block  = sizes_reg[21:0];
	assign iso_quads_per_packet = sizes_reg[31:22];
	assign iso_length           = header_reg[15:0];
	assign iso_tag              = header_reg[17:16];
	assign iso_channel          = header_reg[23:18];
	assign iso_speed            = header_reg[27:26];
	assign iso_sync_bits        = iso_direction == `RFB_DIR_TX ? header_reg[31:28] : 4'h0;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	full_flag_a: assert property (count == (AW + 1)'(DEPTH) && !ovr_reg |-> status_rd[0])
		else $error("full flag missing");
	afull_flag_a: assert property (!ovr_reg |-> status_rd[1] == (free == (AW + 1)'(1)))
		else $error("almost full flag wrong");
	four_space_a: assert property (!ovr_reg |-> status_rd[4] == (free >= (AW + 1)'(4)))
		else $error("four space flag wrong");
	four_present_a: assert property (!ovr_reg |-> status_rd[12] == (count >= (AW + 1)'(4)))
		else $error("four present flag wrong");
	aempty_flag_a: assert property (!ovr_reg |-> status_rd[14] == (count == (AW + 1)'(1)))
		else $error("almost empty flag wrong");
	empty_read_a: assert property (count == '0 && !in_valid && rd_en |=> count == '0)
		else $error("empty read changed fifo");
	clear_fifo_a: assert property (clear_fifo |=> count == '0)
		else $error("clear did not empty fifo");
	remain_field_a: assert property (levels_rd[31:26] == 6'(count))
		else $error("remaining count wrong");
	diag_block_a: assert property (wr_status && !diag_register_write |=> !ovr_reg)
		else $error("flag write without enable");

	// Flags that the first group leaves out, and the storage they sit beside
	empty_flag_a: assert property (!ovr_reg |-> status_rd[15] == (count == '0))
		else $error("empty flag wrong");
	full_refuse_a: assert property (count == (AW + 1)'(DEPTH) && rx_accept
		&& !rd_data |-> !rx_ready)
		else $error("full fifo still ready");
	size_hold_a: assert property (!wr_status |=> $stable(status_reg))
		else $error("status storage changed without a write");
	reserved_zero_a: assert property ((status_rd & 32'h03FE2FEC) == 32'h0
		&& (levels_rd & 32'h0303FFFF) == 32'h0)
		else $error("reserved status bit set");

	// ----------------------------------------------------------------
	// Multi-step checks: host pops, link pushes, register writes
	// ----------------------------------------------------------------
	// A data-port read that really takes the head word
	sequence data_pop_s;
		rd_data && !clear_fifo;
	endsequence

	// The same pop with no link push beside it, so the count must fall
	sequence pop_only_s;
		data_pop_s ##0 !(in_valid && fifo_ready_in);
	endsequence

	// A data-port read while nothing is held
	sequence empty_read_s;
		rd_en && host_addr == `RFB_OFS_RX_DATA && !fifo_valid;
	endsequence

	// A packet's first quadlet landing in an empty FIFO
	sequence first_push_s;
		in_valid && fifo_ready_in && rx_first && count == '0 && !clear_fifo;
	endsequence

	// An iso word for a disabled port, with no pop or clear beside it
	sequence port_drop_s;
		rx_valid && !rx_accept && !rd_data && !clear_fifo;
	endsequence

	// A status write that carries the diagnostic enable
	sequence diag_write_s;
		wr_status && diag_register_write;
	endsequence

	// Host side of the data port
	data_read_a: assert property (data_pop_s |=>
		host_rdata == 32'($past(fifo_out)))
		else $error("data port returned the wrong word");
	pop_count_a: assert property (pop_only_s |=>
		count == $past(count) - (AW + 1)'(1))
		else $error("data port read did not take one word");
	empty_zero_a: assert property (empty_read_s |=> host_rdata == 32'h0)
		else $error("empty data port read not zero");

	// Link side of the FIFO; a dropped word must leave the count alone
	first_mark_a: assert property (first_push_s |=> status_rd[16])
		else $error("first quadlet marker missing");
	port_drop_a: assert property (port_drop_s |=> $stable(count))
		else $error("disabled port word entered the fifo");
	port_ready_a: assert property (rx_valid && !rx_accept |-> rx_ready)
		else $error("disabled port word stalled the link");

	// Register writes reach the outputs one cycle later
	diag_flags_a: assert property (diag_write_s |=> ovr_reg
		&& (status_rd & `RFB_FLAG_MASK) == ($past(host_wdata) & `RFB_FLAG_MASK))
		else $error("diagnostic flag write not held");
	sizes_write_a: assert property (wr_sizes |=>
		{iso_quads_per_packet, iso_quads_per_block} == $past(host_wdata))
		else $error("block and packet counts not stored");
	dir_write_a: assert property (wr_dir |=>
		{iso_direction, iso_start_enable} == 3'($past(host_wdata)))
		else $error("start enable or direction not stored");
	header_write_a: assert property (wr_header |=>
		{iso_speed, 2'h0, iso_channel, iso_tag, iso_length}
		== (28'($past(host_wdata)) & 28'hCFFFFFF))
		else $error("header fields not stored");
	sync_gate_a: assert property (iso_direction != `RFB_DIR_TX |->
		iso_sync_bits == 4'h0)
		else $error("sync bits outside transmit");
	sync_pass_a: assert property (iso_direction == `RFB_DIR_TX |->
		iso_sync_bits == header_reg[31:28])
		else $error("sync bits not passed in transmit");
endmodule // rfb_bank

//--- logic/rfb_pkg.sv
// Types shared by the receive FIFO register bank
package rfb_pkg;
	typedef logic [31:0] rfb_word_t;
	typedef logic [7:0]  rfb_addr_t;
endpackage

//--- logic/rfb_regs.svh
// Register offsets, field positions and reset values of the receive FIFO register bank
`ifndef RFB_REGS_SVH
`define RFB_REGS_SVH
// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define RFB_OFS_RX_STATUS   8'h3C
`define RFB_OFS_FILL_LEVELS 8'h50
`define RFB_OFS_ISO_SIZES   8'h54
`define RFB_OFS_ISO_DIR     8'h58
`define RFB_OFS_ISO_HEADER  8'h5C
`define RFB_OFS_RX_DATA     8'hC0
// ----------------------------------------------------------------
// Receive FIFO status fields, numbered from the LSB
// ----------------------------------------------------------------
`define RFB_BIT_FULL        0
`define RFB_BIT_ALMOST_FULL 1
`define RFB_BIT_FOUR_SPACE  4
`define RFB_BIT_FOUR_PRES   12
`define RFB_BIT_ALMOST_EMPT 14
`define RFB_BIT_EMPTY       15
`define RFB_BIT_FIRST_QUAD  16
`define RFB_BIT_CLEAR       19
`define RFB_SIZE_LSB        26
`define RFB_SIZE_RESET      6'h32
`define RFB_STATUS_RESET    32'h00000000
`define RFB_FLAG_MASK       32'h0000D013
// ----------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------
`define RFB_TX_REMAIN_LSB   18
`define RFB_RX_REMAIN_LSB   26
`define RFB_ISO_DIR_MASK    32'h00000007
`define RFB_ISO_HDR_MASK    32'hFCFFFFFF
`define RFB_DIR_TX          2'h0
`define RFB_DIR_RX          2'h1
`endif

//--- verification/rfb_link_model.sv
// Link-side source model that pushes quadlets into the receive FIFO
`timescale 1ns/1ps
module rfb_link_model (
	input  wire logic          clk,
	input  wire logic          rx_ready,
	output logic               rx_valid,
	output logic               rx_iso,
	output logic               rx_port,
	output logic               rx_first,
	output rfb_pkg::rfb_word_t rx_data
);
	// Idle data is the inverse of the last word, so a stale value never looks right
	initial begin
		rx_valid = 1'b0;
		{rx_iso, rx_port, rx_first} = 3'h0;
		rx_data = 32'hFFFFFFFF;
	end
	// Offer one quadlet, hold it until taken; a refused word is given up after four edges
	task automatic send(input rfb_pkg::rfb_word_t d, input logic iso, input logic port,
		input logic first, output logic ok);
		int n;
		@(negedge clk);
		rx_valid = 1'b1;
		{rx_iso, rx_port, rx_first} = {iso, port, first};
		rx_data = d;
		ok = 1'b0;
		for (n = 0; n < 4 && !ok; n++) begin
			@(posedge clk);
			ok = rx_ready;
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data = ~d;
	endtask
endmodule // rfb_link_model

//--- verification/test_receive_fifo_iso_register_bank.sv
// Self-checking bench of the receive FIFO register bank
`timescale 1ns/1ps
`include "rfb_regs.svh"
module test_receive_fifo_iso_register_bank;
	localparam int D = 16;
	logic               clk, nrst, cs, wr, rd_s, diag, v_valid, v_iso, v_port, v_first;
	logic               v_ready, o_en, ok, keep;
	logic [1:0]         pen, o_dir, o_tag, o_spd;
	logic [5:0]         txr, o_ch;
	logic [21:0]        o_qpb;
	logic [9:0]         o_qpp;
	logic [15:0]        o_len;
	logic [3:0]         o_sync;
	rfb_pkg::rfb_addr_t addr;
	rfb_pkg::rfb_word_t wdata, rdata, v_data, w, h;
	logic [32:0]        q[$];
	logic [31:0]        seed = 32'h00000052;
	int                 n_errors, checks_done, i;

	rfb_bank #(.DEPTH(D)) i_dut (.clk(clk), .nrst(nrst), .host_cs(cs), .host_wr(wr),
		.host_rd(rd_s), .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata),
		.diag_register_write(diag), .iso_receive_port_enable(pen), .rx_valid(v_valid),
		.rx_iso(v_iso), .rx_port(v_port), .rx_first(v_first), .rx_data(v_data),
		.rx_ready(v_ready), .tx_fifo_remaining(txr), .iso_start_enable(o_en),
		.iso_direction(o_dir), .iso_quads_per_block(o_qpb), .iso_quads_per_packet(o_qpp),
		.iso_length(o_len), .iso_tag(o_tag), .iso_channel(o_ch), .iso_speed(o_spd),
		.iso_sync_bits(o_sync));
	rfb_link_model i_link (.clk(clk), .rx_ready(v_ready), .rx_valid(v_valid),
		.rx_iso(v_iso), .rx_port(v_port), .rx_first(v_first), .rx_data(v_data));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected status word from the FIFO fill level and the head marker
	function automatic rfb_pkg::rfb_word_t stat(input int n, input logic f);
		rfb_pkg::rfb_word_t r;
		r = {6'h32, 26'h0};
		r[0] = (n == D);
		r[1] = (n == D - 1);
		r[4] = (D - n >= 4);
		r[12] = (n >= 4);
		r[14] = (n == 1);
		r[15] = (n == 0);
		r[16] = f;
		return r;
	endfunction
	task automatic check(input rfb_pkg::rfb_word_t seen, input rfb_pkg::rfb_word_t want);
		checks_done++;
		if (seen !== want) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	// One host access; the strobe is held across exactly one rising edge
	task automatic acc(input logic w_n, input rfb_pkg::rfb_addr_t a, input rfb_pkg::rfb_word_t d);
		@(negedge clk);
		{cs, wr, rd_s, addr, wdata} = {1'b1, w_n, !w_n, a, d};
		@(negedge clk);
		{cs, wr, rd_s} = 3'h0;
	endtask
	task automatic rd(input rfb_pkg::rfb_addr_t a, input rfb_pkg::rfb_word_t want);
		acc(1'b0, a, 32'h0);
		check(rdata, want);
	endtask
	task automatic lvl();
		rd(`RFB_OFS_RX_STATUS, stat(q.size(), q.size() > 0 && q[0][32]));
		rd(`RFB_OFS_FILL_LEVELS, {6'(q.size()), 2'h0, txr, 18'h0});
	endtask
	task automatic print_verdict();
		$display("errors %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// The sequence needs several hundred cycles; this span is far beyond it
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
	initial begin
		{nrst, cs, wr, rd_s, diag, addr, wdata} = '0;
		pen = 2'h1;
		w = rnd();
		txr = w[5:0];
		repeat (20) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		lvl();
		rd(`RFB_OFS_ISO_DIR, 32'h0);
		rd(`RFB_OFS_ISO_HEADER, 32'h0);
		acc(1'b1, 8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		// Every direction code, with random counts and header fields
		for (i = 0; i < 4; i++) begin
			w = rnd();
			h = rnd();
			acc(1'b1, `RFB_OFS_ISO_SIZES, w);
			acc(1'b1, `RFB_OFS_ISO_DIR, {w[31:3], i[1:0], w[0]});
			acc(1'b1, `RFB_OFS_ISO_HEADER, h);
			rd(`RFB_OFS_ISO_SIZES, w);
			rd(`RFB_OFS_ISO_DIR, {29'h0, i[1:0], w[0]});
			rd(`RFB_OFS_ISO_HEADER, h & `RFB_ISO_HDR_MASK);
			check({o_qpp, o_qpb}, w);
			check({29'h0, o_dir, o_en}, {29'h0, i[1:0], w[0]});
			h[31:28] = (i == 0) ? h[31:28] : 4'h0;
			check({o_sync, o_spd, 2'h0, o_ch, o_tag, o_len}, h & `RFB_ISO_HDR_MASK);
		end
		// Receive direction set: iso words still land when their port is enabled
		acc(1'b1, `RFB_OFS_ISO_DIR, 32'h00000002);
		w = rnd();
		txr = w[5:0];
		for (i = 0; i < 40; i++) begin
			w = rnd();
			// Both port enables are drawn at random, so each port is seen on and off
			pen = w[4:3];
			keep = !w[0] || pen[w[1]];
			i_link.send(w, w[0], w[1], w[2], ok);
			check({31'h0, ok}, {31'h0, !keep || q.size() < D});
			if (keep && q.size() < D)
				q.push_back({w[2], w});
			lvl();
		end
		// Flag writes are ignored without the diagnostic enable, latched with it
		acc(1'b1, `RFB_OFS_RX_STATUS, 32'hC800D013);
		lvl();
		diag = 1'b1;
		acc(1'b1, `RFB_OFS_RX_STATUS, 32'hC8000012);
		w = stat(q.size(), q.size() > 0 && q[0][32]) & ~`RFB_FLAG_MASK;
		rd(`RFB_OFS_RX_STATUS, w | 32'h00000012);
		diag = 1'b0;
		acc(1'b1, `RFB_OFS_RX_STATUS, 32'hC8000000);
		// Drain through the data port, then read once more while empty
		while (q.size() > 0) begin
			lvl();
			rd(`RFB_OFS_RX_DATA, q[0][31:0]);
			void'(q.pop_front());
		end
		rd(`RFB_OFS_RX_DATA, 32'h0);
		lvl();
		// Clear discards everything held and reads back as zero
		for (i = 0; i < 5; i++) begin
			w = rnd();
			i_link.send(w, 1'b0, 1'b0, 1'b1, ok);
			q.push_back({1'b1, w});
		end
		lvl();
		acc(1'b1, `RFB_OFS_RX_STATUS, 32'hC8080000);
		q.delete();
		lvl();
		print_verdict();
	end
endmodule // test_receive_fifo_iso_register_bank
